// [src/ccrb_pkg.sv]
// Constants and state types for the processor control register bank.
// Assumes one core clock; software reaches the bank over AXI4-Lite.
package ccrb_pkg;
    localparam int          CCRB_ADDR_W     = 8;

    // Register byte offsets
    localparam logic [7:0]  OFS_SYS_MODE    = 8'h00;
    localparam logic [7:0]  OFS_RSVD_SLOT   = 8'h04;
    localparam logic [7:0]  OFS_FAULT_ADDR  = 8'h08;
    localparam logic [7:0]  OFS_PT_ROOT     = 8'h0c;
    localparam logic [7:0]  OFS_EXT_FEAT    = 8'h10;
    localparam logic [7:0]  OFS_CFG_CTRL2   = 8'h14;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h18;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h1c;

    // System-mode field positions
    localparam int          BIT_PAGING      = 31;
    localparam int          BIT_FILL_INH    = 30;
    localparam int          BIT_WB_SEL      = 29;
    localparam int          BIT_ALIGN_MSK   = 18;
    localparam int          BIT_PROT        = 0;
    localparam logic [31:0] SYS_WMASK       = 32'he004_0001;
    localparam logic [31:0] SYS_RESET       = 32'h0000_0000;

    // Page-table root and extended-feature layouts
    localparam logic [31:0] PT_WMASK        = 32'hffff_f000;
    localparam int          PDB_LSB         = 12;
    localparam int          BIT_TICK        = 2;
    localparam logic        TICK_RESET      = 1'b1;

    // Configuration control 2: write-back select lock
    localparam int          BIT_WB_LOCK     = 2;

    // Interrupt status layout
    localparam int          IRQ_W           = 2;
    localparam int          IRQ_FAULT       = 0;
    localparam int          IRQ_DENIED      = 1;

    localparam logic [1:0]  PRIV_LEVEL0     = 2'h0;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef struct packed {
        logic [31:0]      sys_mode;
        logic [31:0]      pt_root;
        logic [31:0]      fault_addr;
        logic             tick_restrict;
        logic             wb_lock;
        logic [IRQ_W-1:0] sts;
        logic [IRQ_W-1:0] msk;
        logic             paging_active;
    } ccrb_bank_s;

    typedef struct packed {
        logic                   aw_held;
        logic [CCRB_ADDR_W-1:0] awaddr;
        logic                   awpriv;
        logic                   w_held;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } ccrb_slave_s;
endpackage

// [src/ccrb_req_if.sv]
// Request path between the bus slave and the register bank.
// Assumes both ends share aclk; requests are one-cycle strobes.
`timescale 1ns/1ps
interface ccrb_req_if;
    logic                            wr_req;
    logic [ccrb_pkg::CCRB_ADDR_W-1:0] wr_addr;
    logic [31:0]                     wr_data;
    logic [3:0]                      wr_strb;
    logic                            wr_priv;
    logic                            wr_err;
    logic                            rd_req;
    logic [ccrb_pkg::CCRB_ADDR_W-1:0] rd_addr;
    logic                            rd_priv;
    logic [31:0]                     rd_data;
    logic                            rd_err;

    modport slave (output wr_req, wr_addr, wr_data, wr_strb, wr_priv,
                   output rd_req, rd_addr, rd_priv,
                   input  wr_err, rd_data, rd_err);
    modport bank  (input  wr_req, wr_addr, wr_data, wr_strb, wr_priv,
                   input  rd_req, rd_addr, rd_priv,
                   output wr_err, rd_data, rd_err);
endinterface

// [src/ccrb_axil_slave.sv]
// AXI4-Lite slave that turns bus transfers into bank request strobes.
// Assumes the bank answers each strobe combinationally in the same cycle.
`timescale 1ns/1ps
module ccrb_axil_slave
    import ccrb_pkg::*;
(
    // Clock, reset and clock enable
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   ce,
    // Write channels
    input  wire logic [CCRB_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]             awprot,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    // Read channels
    input  wire logic [CCRB_ADDR_W-1:0] araddr,
    input  wire logic [2:0]             arprot,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    // Bank side
    ccrb_req_if.slave                   req
);
    ccrb_slave_s st_ff;
    ccrb_slave_s nxt_st;

    // Address and data are held separately, so either may arrive first
    assign awready = ce && !st_ff.aw_held;
    assign wready  = ce && !st_ff.w_held;
    assign arready = ce && !st_ff.rvalid;
    assign bvalid  = st_ff.bvalid;
    assign bresp   = st_ff.bresp;
    assign rvalid  = st_ff.rvalid;
    assign rdata   = st_ff.rdata;
    assign rresp   = st_ff.rresp;

    assign req.wr_req  = ce && st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    assign req.wr_addr = st_ff.awaddr;
    assign req.wr_data = st_ff.wdata;
    assign req.wr_strb = st_ff.wstrb;
    assign req.wr_priv = st_ff.awpriv;
    assign req.rd_req  = arvalid && arready;
    assign req.rd_addr = araddr;
    assign req.rd_priv = arprot[0];

    always_comb
    begin
        nxt_st = st_ff;
        if (awvalid && awready)
        begin
            nxt_st.aw_held = 1'b1;
            nxt_st.awaddr  = awaddr;
            nxt_st.awpriv  = awprot[0];
        end
        if (wvalid && wready)
        begin
            nxt_st.w_held = 1'b1;
            nxt_st.wdata  = wdata;
            nxt_st.wstrb  = wstrb;
        end
        if (req.wr_req)
        begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = req.wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        else if (st_ff.bvalid && bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        if (req.rd_req)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = req.rd_data;
            nxt_st.rresp  = req.rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        else if (st_ff.rvalid && rready)
        begin
            nxt_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= '0;
        end
        else if (ce)
        begin
            st_ff <= nxt_st;
        end
    end
endmodule // ccrb_axil_slave

// [src/ccrb_top.sv]
// Processor control register bank with its mode outputs to the core.
// Assumes core events arrive synchronous to aclk as one-cycle pulses.
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module ccrb_top
(
    // Clock, reset and clock enable
    input  wire logic                             aclk,
    input  wire logic                             aresetn,
    input  wire logic                             ce,
    // AXI4-Lite write address
    input  wire logic [ccrb_pkg::CCRB_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                       s_axi_awprot,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    // AXI4-Lite write data and response
    input  wire logic [31:0]                      s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    output logic [1:0]                            s_axi_bresp,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ccrb_pkg::CCRB_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                       s_axi_arprot,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    output logic [31:0]                           s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    // Core events and state
    input  wire logic [1:0]                       current_privilege_level,
    input  wire logic                             page_fault,
    input  wire logic [31:0]                      faulting_linear_address,
    input  wire logic                             branch_exec,
    input  wire logic                             alignment_check_flag,
    input  wire logic                             misaligned_access,
    // Mode outputs
    output logic                                  protected_mode,
    output logic                                  paging_enable,
    output logic [19:0]                           page_directory_base,
    output logic                                  read_tick_permit,
    output logic                                  line_fill_enable,
    output logic                                  hit_serve_enable,
    output logic                                  write_update_enable,
    output logic                                  snoop_invalidate_enable,
    output logic                                  writeback_mode,
    output logic                                  write_through_all,
    output logic                                  alignment_fault,
    // Interrupt
    output logic                                  irq
);
    import ccrb_pkg::*;

    ccrb_req_if   req ();
    ccrb_bank_s   st_ff;
    ccrb_bank_s   nxt_st;
    logic [31:0]  wr_val;
    logic         wr_ok;
    logic         wr_denied;
    logic         rd_denied;
    logic [IRQ_W-1:0] evt;

    ccrb_axil_slave u_slave
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .awaddr  (s_axi_awaddr),
        .awprot  (s_axi_awprot),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arprot  (s_axi_arprot),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .req     (req.slave)
    );

    // Byte-lane merge, then keep only the bits the register implements
    function automatic logic [31:0] merge
    (
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  strb,
        input logic [31:0] wmask
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return (res & wmask) | (old & ~wmask);
    endfunction

    // Offsets the bank answers; anything else gets SLVERR
    function automatic logic is_mapped(input logic [CCRB_ADDR_W-1:0] a);
        case (a)
            OFS_SYS_MODE, OFS_RSVD_SLOT, OFS_FAULT_ADDR, OFS_PT_ROOT,
            OFS_EXT_FEAT, OFS_CFG_CTRL2, OFS_IRQ_STATUS, OFS_IRQ_MASK:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction

    // Access is refused to unprivileged masters only in protected mode
    assign wr_denied = st_ff.sys_mode[BIT_PROT] && !req.wr_priv;
    assign rd_denied = st_ff.sys_mode[BIT_PROT] && !req.rd_priv;
    assign wr_ok     = req.wr_req && is_mapped(req.wr_addr) && !wr_denied;

    // Write path
    always_comb
    begin
        nxt_st     = st_ff;
        wr_val     = 32'h0000_0000;
        req.wr_err = req.wr_req && !(is_mapped(req.wr_addr) && !wr_denied);
        evt        = '0;
        evt[IRQ_DENIED] = (req.wr_req && wr_denied)
                        || (req.rd_req && rd_denied);
        if (wr_ok)
        begin
            case (req.wr_addr)
                OFS_SYS_MODE:
                begin
                    wr_val = merge(st_ff.sys_mode, req.wr_data,
                                   req.wr_strb, SYS_WMASK);
                    if (st_ff.wb_lock)
                    begin
                        wr_val[BIT_WB_SEL] = st_ff.sys_mode[BIT_WB_SEL];
                    end
                    nxt_st.sys_mode = wr_val;
                end
                OFS_FAULT_ADDR:
                begin
                    nxt_st.fault_addr = merge(st_ff.fault_addr,
                                              req.wr_data, req.wr_strb,
                                              32'hffff_ffff);
                end
                OFS_PT_ROOT:
                begin
                    nxt_st.pt_root = merge(st_ff.pt_root, req.wr_data,
                                           req.wr_strb, PT_WMASK);
                end
                OFS_EXT_FEAT:
                begin
                    wr_val = merge({29'h0, st_ff.tick_restrict, 2'h0},
                                   req.wr_data, req.wr_strb,
                                   32'hffff_ffff);
                    nxt_st.tick_restrict = wr_val[BIT_TICK];
                end
                OFS_CFG_CTRL2:
                begin
                    wr_val = merge({29'h0, st_ff.wb_lock, 2'h0},
                                   req.wr_data, req.wr_strb,
                                   32'hffff_ffff);
                    nxt_st.wb_lock = wr_val[BIT_WB_LOCK];
                end
                OFS_IRQ_STATUS:
                begin
                    wr_val = merge(32'h0, req.wr_data, req.wr_strb,
                                   32'hffff_ffff);
                    nxt_st.sts = st_ff.sts & ~wr_val[IRQ_W-1:0];
                end
                OFS_IRQ_MASK:
                begin
                    wr_val = merge({30'h0, st_ff.msk}, req.wr_data,
                                   req.wr_strb, 32'hffff_ffff);
                    nxt_st.msk = wr_val[IRQ_W-1:0];
                end
                default:
                begin
                    // Reserved slot: write is accepted and discarded
                    nxt_st.sys_mode = st_ff.sys_mode;
                end
            endcase
        end

        // Hardware capture wins over a software write in the same cycle
        if (page_fault && st_ff.paging_active)
        begin
            nxt_st.fault_addr = faulting_linear_address;
            evt[IRQ_FAULT]    = 1'b1;
        end

        // The paging state seen by the core moves only on a branch
        if (branch_exec)
        begin
            nxt_st.paging_active = st_ff.sys_mode[BIT_PAGING]
                                 && st_ff.sys_mode[BIT_PROT];
        end

        // Set wins over a write-one-to-clear in the same cycle
        nxt_st.sts = nxt_st.sts | evt;
    end

    // Read path
    always_comb
    begin
        req.rd_data = 32'h0000_0000;
        req.rd_err  = req.rd_req && !(is_mapped(req.rd_addr) && !rd_denied);
        if (req.rd_req && !req.rd_err)
        begin
            case (req.rd_addr)
                OFS_SYS_MODE:
                    req.rd_data = st_ff.sys_mode & SYS_WMASK;
                OFS_FAULT_ADDR:
                    req.rd_data = st_ff.fault_addr;
                OFS_PT_ROOT:
                    req.rd_data = st_ff.pt_root & PT_WMASK;
                OFS_EXT_FEAT:
                    req.rd_data = {29'h0, st_ff.tick_restrict, 2'h0};
                OFS_CFG_CTRL2:
                    req.rd_data = {29'h0, st_ff.wb_lock, 2'h0};
                OFS_IRQ_STATUS:
                    req.rd_data = {30'h0, st_ff.sts};
                OFS_IRQ_MASK:
                    req.rd_data = {30'h0, st_ff.msk};
                default:
                    req.rd_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff.sys_mode      <= SYS_RESET;
            st_ff.pt_root       <= 32'h0000_0000;
            st_ff.fault_addr    <= 32'h0000_0000;
            st_ff.tick_restrict <= TICK_RESET;
            st_ff.wb_lock       <= 1'b0;
            st_ff.sts           <= '0;
            st_ff.msk           <= '0;
            st_ff.paging_active <= 1'b0;
        end
        else if (ce)
        begin
            st_ff <= nxt_st;
        end
    end

    // Mode outputs to the core
    assign protected_mode      = st_ff.sys_mode[BIT_PROT];
    assign paging_enable       = st_ff.paging_active;
    assign page_directory_base = st_ff.pt_root[31:PDB_LSB];
    // Level 0 may always read the tick counter
    assign read_tick_permit    = !st_ff.tick_restrict
                               || (current_privilege_level == PRIV_LEVEL0);
    // Inhibit only blocks fills; a full stop needs software to invalidate
    assign line_fill_enable        = !st_ff.sys_mode[BIT_FILL_INH];
    assign hit_serve_enable        = 1'b1;
    assign write_update_enable     = 1'b1;
    assign snoop_invalidate_enable = 1'b1;
    assign writeback_mode      = st_ff.sys_mode[BIT_WB_SEL];
    assign write_through_all   = !st_ff.sys_mode[BIT_WB_SEL];
    assign alignment_fault     = st_ff.sys_mode[BIT_ALIGN_MSK]
                               && alignment_check_flag && misaligned_access;
    assign irq                 = |(st_ff.sts & st_ff.msk);
endmodule // ccrb_top

// [tb/ccrb_props.sv]
// Checker for the control register bank, seen from its top ports.
// Assumes one aclk domain; bound to ccrb_top below.
`timescale 1ns/1ps
module ccrb_props
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Read channel and write response valid
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [2:0]  s_axi_arprot,
    input wire logic        s_axi_rvalid,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    // Core side
    input wire logic [1:0]  current_privilege_level,
    input wire logic        branch_exec,
    input wire logic        alignment_check_flag,
    input wire logic        misaligned_access,
    input wire logic        protected_mode,
    input wire logic        paging_enable,
    input wire logic        read_tick_permit,
    input wire logic        line_fill_enable,
    input wire logic        writeback_mode,
    input wire logic        write_through_all,
    input wire logic        alignment_fault
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_tick_level0: assert property (
        current_privilege_level == 2'h0 |-> read_tick_permit)
        else $error("tick read refused at level zero");
    a_wt_inverse: assert property (
        write_through_all == !writeback_mode)
        else $error("write-through not inverse of write-back");
    a_align_cause: assert property (
        alignment_fault |-> alignment_check_flag && misaligned_access)
        else $error("alignment fault without cause");
    a_paging_branch: assert property (
        $changed(paging_enable) |-> $past(branch_exec))
        else $error("paging changed without branch");
    a_paging_prot: assert property (
        $rose(paging_enable) |-> $past(protected_mode))
        else $error("paging on outside protected mode");
    a_read_refused: assert property (
        s_axi_arvalid && s_axi_arready && !s_axi_arprot[0]
        && protected_mode |=> s_axi_rvalid && s_axi_rresp == 2'h2
        && s_axi_rdata == 32'h0)
        else $error("unprivileged read not refused");
    a_mode_on_resp: assert property (
        $changed(protected_mode) |-> $rose(s_axi_bvalid))
        else $error("mode changed without write response");
    a_fill_on_resp: assert property (
        $changed(line_fill_enable) |-> $rose(s_axi_bvalid))
        else $error("fill enable changed without write");

    c_paging: cover property (paging_enable);
    c_align: cover property (alignment_fault);
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // ccrb_props

bind ccrb_top ccrb_props i_props (.*);

// [tb/ccrb_top_test.sv]
// Self-checking bench for the control register bank.
// Drives AXI4-Lite and core events; checks registers and mode outputs.
`timescale 1ns/1ps
module ccrb_top_test;
    import ccrb_pkg::*;
    logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic [CCRB_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, faulting_linear_address;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, current_privilege_level;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_arvalid, s_axi_rready, s_axi_rvalid, irq, page_fault;
    logic branch_exec, alignment_check_flag, misaligned_access;
    logic protected_mode, paging_enable, read_tick_permit, line_fill_enable;
    logic hit_serve_enable, write_update_enable, snoop_invalidate_enable;
    logic writeback_mode, write_through_all, alignment_fault;
    logic [19:0] page_directory_base;
    int num_errors, total_checks;

    ccrb_top i_dut (.*);

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stuck;
        chk("response", 32'h1, 32'h0);
        give_verdict();
    endtask

    // Both channels offered together; each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic p, input logic [1:0] er);
        logic ta, tw, tb;
        tb = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awprot <= {2'h0, p};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40 && !tb; n++)
        begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            if (tb)
                chk("bresp", 32'(er), 32'(s_axi_bresp));
            @(posedge aclk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
        end
        if (!tb)
            stuck();
    endtask

    task automatic rd(input logic [7:0] a, input logic p,
                      input logic [1:0] er, input logic [31:0] ed);
        logic ta, tr;
        tr = 1'b0;
        s_axi_araddr <= a;
        s_axi_arprot <= {2'h0, p};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40 && !tr; n++)
        begin
            @(negedge aclk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid;
            if (tr)
            begin
                chk("rresp", 32'(er), 32'(s_axi_rresp));
                chk("rdata", ed, s_axi_rdata);
            end
            @(posedge aclk);
            if (ta)
                s_axi_arvalid <= 1'b0;
        end
        if (!tr)
            stuck();
    endtask

    // Branch pulse, then a settled look at the mode outputs
    task automatic branch;
        branch_exec <= 1'b1;
        @(posedge aclk);
        branch_exec <= 1'b0;
        @(negedge aclk);
    endtask

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, page_fault, branch_exec} = 4'h0;
        {alignment_check_flag, misaligned_access} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        {s_axi_wdata, faulting_linear_address} = '0;
        current_privilege_level = 2'h0;
        ce = 1'b1;
        s_axi_wstrb = 4'hf;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFS_EXT_FEAT, 1'b1, RESP_OKAY, 32'h4);
        rd(OFS_SYS_MODE, 1'b1, RESP_OKAY, 32'h0);
        wr(OFS_EXT_FEAT, 32'hffff_ffff, 1'b1, RESP_OKAY);
        rd(OFS_EXT_FEAT, 1'b1, RESP_OKAY, 32'h4);
        current_privilege_level <= 2'h3;
        @(negedge aclk);
        chk("tick", 32'h0, 32'(read_tick_permit));
        chk("wt", 32'h1, 32'(write_through_all));
        @(posedge aclk);
        wr(OFS_EXT_FEAT, 32'h0, 1'b1, RESP_OKAY);
        @(negedge aclk);
        chk("tick", 32'h1, 32'(read_tick_permit));
        @(posedge aclk);
        wr(OFS_PT_ROOT, 32'hffff_ffff, 1'b1, RESP_OKAY);
        rd(OFS_PT_ROOT, 1'b1, RESP_OKAY, 32'hffff_f000);
        wr(OFS_RSVD_SLOT, 32'hffff_ffff, 1'b1, RESP_OKAY);
        rd(OFS_RSVD_SLOT, 1'b1, RESP_OKAY, 32'h0);
        wr(OFS_SYS_MODE, 32'hffff_ffff, 1'b1, RESP_OKAY);
        rd(OFS_SYS_MODE, 1'b1, RESP_OKAY, 32'he004_0001);
        {alignment_check_flag, misaligned_access} <= 2'h3;
        @(negedge aclk);
        chk("pdb", 32'hf_ffff, 32'(page_directory_base));
        chk("prot", 32'h1, 32'(protected_mode));
        chk("fill", 32'h0, 32'(line_fill_enable));
        chk("wb", 32'h1, 32'(writeback_mode));
        chk("wt", 32'h0, 32'(write_through_all));
        chk("align", 32'h1, 32'(alignment_fault));
        chk("pg", 32'h0, 32'(paging_enable));
        chk("keep", 32'h7, 32'({hit_serve_enable, write_update_enable,
                                snoop_invalidate_enable}));
        @(posedge aclk);
        branch();
        chk("pg", 32'h1, 32'(paging_enable));
        @(posedge aclk);
        // Mask only the fault bit, so a refusal alone leaves irq low
        wr(OFS_IRQ_MASK, 32'h1, 1'b1, RESP_OKAY);
        rd(OFS_PT_ROOT, 1'b0, RESP_SLVERR, 32'h0);
        wr(OFS_PT_ROOT, 32'h0, 1'b0, RESP_SLVERR);
        rd(OFS_PT_ROOT, 1'b1, RESP_OKAY, 32'hffff_f000);
        chk("irq", 32'h0, 32'(irq));
        wr(OFS_IRQ_MASK, 32'h3, 1'b1, RESP_OKAY);
        chk("irq", 32'h1, 32'(irq));
        wr(OFS_IRQ_STATUS, 32'h2, 1'b1, RESP_OKAY);
        rd(OFS_IRQ_STATUS, 1'b1, RESP_OKAY, 32'h0);
        chk("irq", 32'h0, 32'(irq));
        faulting_linear_address <= 32'h1234_5678;
        page_fault <= 1'b1;
        @(posedge aclk);
        page_fault <= 1'b0;
        rd(OFS_FAULT_ADDR, 1'b1, RESP_OKAY, 32'h1234_5678);
        rd(OFS_IRQ_STATUS, 1'b1, RESP_OKAY, 32'h1);
        wr(OFS_CFG_CTRL2, 32'h4, 1'b1, RESP_OKAY);
        wr(OFS_SYS_MODE, 32'h8000_0000, 1'b1, RESP_OKAY);
        rd(OFS_SYS_MODE, 1'b0, RESP_OKAY, 32'ha000_0000);
        branch();
        chk("pg", 32'h0, 32'(paging_enable));
        chk("fill", 32'h1, 32'(line_fill_enable));
        chk("align", 32'h0, 32'(alignment_fault));
        @(posedge aclk);
        wr(8'h20, 32'h1, 1'b1, RESP_SLVERR);
        rd(8'h20, 1'b1, RESP_SLVERR, 32'h0);
        give_verdict();
    end
endmodule // ccrb_top_test
